// ---- bench/tb.sv ----
`timescale 1ns/1ps

// ****************************************
// Self-checking bench for the dual timer
// ****************************************
module tb;
  import dtp_pkg::*;

  logic i_core_clk;
  logic i_rstn;
  logic i_clk_en;
  logic i_emu_halt;
  logic [7:0] div_r;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic [1:0] tick;
  logic [1:0] evt;
  dtp_pins_s pins_a;
  dtp_pins_s pins_b;
  logic [7:0] rd_v;
  int errors;
  int checks;
  int n_tick [2];
  int n_ev [2];
  int n_hi [2];
  logic [7:0] rb_v [8] = '{8'h0D, 8'hA5, 8'h5A, 8'hC3, 8'h0E, 8'h3C, 8'h66, 8'h81};
  logic [7:0] pw_s [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80};
  logic [7:0] pw_b [7] = '{8'h09, 8'hFF, 8'h7F, 8'h00, 8'h3F, 8'hC8, 8'h1F};
  int pw_h [7] = '{20, 512, 256, 8, 512, 512, 256};
  logic [7:0] pr_s [4] = '{8'h00, 8'h22, 8'h41, 8'h60};
  int pr_n [4] = '{192, 16, 6, 3};
  int src_n [9] = '{0, 256, 32, 0, 16, 8, 4, 2, 0};

  // Async sources at distinct slow rates so the selected one is identifiable
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  dtp_top uut (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .i_emu_halt(i_emu_halt),
    .i_fast_rc_osc(div_r[2]),
    .i_slow_rc_osc(div_r[3]),
    .i_pin_a0(div_r[4]),
    .i_pin_a3(div_r[5]),
    .i_pin_a4(div_r[6]),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_timer_a_tick(tick[0]),
    .o_timer_b_tick(tick[1]),
    .o_event_a(evt[0]),
    .o_event_b(evt[1]),
    .o_pins_a(pins_a),
    .o_pins_b(pins_b)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    rd_v = o_rdata;
  endtask : rd

  task automatic cfg(input logic t, input logic [7:0] c, input logic [7:0] s,
                     input logic [7:0] b, input int settle);
    wr({1'b0, t, REG_SCALE}, s);
    wr({1'b0, t, REG_BOUND}, b);
    wr({1'b0, t, REG_COUNT}, 8'h00);
    wr({1'b0, t, REG_CTL}, c);
    repeat (settle) @(posedge i_core_clk);
  endtask : cfg

  // Counts ticks, events and high cycles of both timers over a window
  task automatic watch(input int cyc);
    n_tick = '{0, 0};
    n_ev = '{0, 0};
    n_hi = '{0, 0};
    repeat (cyc) begin
      @(negedge i_core_clk);
      for (int k = 0; k < 2; k++) begin
        if (tick[k] === 1'b1) n_tick[k]++;
        if (evt[k] === 1'b1) n_ev[k]++;
      end
      if ((|pins_a.drv) === 1'b1) n_hi[0]++;
      if ((|pins_b.drv) === 1'b1) n_hi[1]++;
    end
  endtask : watch

  task automatic report_and_stop();
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Clock, reset, watchdog
  // ****************************************
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Whole sequence needs roughly 22k cycles
  initial begin
    repeat (60000) @(posedge i_core_clk);
    errors++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    i_rstn = 1'b0;
    i_clk_en = 1'b1;
    i_emu_halt = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    errors = 0;
    checks = 0;
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[3:0]);
      chk("reset value", rd_v, 32'h0);
    end
    // Readback with the clock code at stop so the counter holds
    for (int a = 0; a < 8; a++) wr(a[3:0], rb_v[a]);
    for (int a = 0; a < 8; a++) begin
      rd(a[3:0]);
      chk("readback", rd_v, rb_v[a]);
    end
    wr(4'h9, 8'hFF);
    rd(4'h1);
    chk("unmapped write", rd_v, 32'hA5);
    rd(4'h9);
    chk("unmapped read", rd_v, 32'h0);
    // Output routing for every select code, both timers
    for (int k = 0; k < 4; k++) begin
      wr(ADR_CTL_A, 8'(k << 2));
      wr(ADR_CTL_B, 8'(k << 2));
      @(negedge i_core_clk);
      chk("oe a", pins_a.oe, (k == 0) ? 0 : (1 << (k - 1)));
      chk("oe b", pins_b.oe, (k == 0) ? 0 : (1 << (k - 1)));
    end
    // Prescaler and scaler, long settle flushes the old scaler state
    for (int k = 0; k < 4; k++) begin
      cfg(1'b0, 8'h10, pr_s[k], 8'hFF, 2200);
      watch(192);
      chk("tick rate", n_tick[0], pr_n[k]);
    end
    // Period mode, system clock, output on pin_a3
    for (int b = 1; b < 4; b += 2) begin
      cfg(1'b0, 8'h18, 8'h00, b[7:0], 20);
      watch(40);
      chk("period oe", pins_a.oe, 32'h2);
      chk("period ticks", n_tick[0], 40);
      chk("period events", n_ev[0], 40 / (b + 1));
      chk("period high", n_hi[0], 20);
    end
    cfg(1'b0, 8'h18, 8'h21, 8'h01, 2200);
    watch(128);
    chk("scaled events", n_ev[0], 8);
    chk("scaled high", n_hi[0], 64);
    wr(ADR_CTL_A, 8'h00);
    rd(ADR_COUNT_A);
    chk("count within bound", (rd_v <= 8'h01), 32'h1);
    // PWM, alternating timers, 8-bit and 6-bit, full scale and above
    for (int k = 0; k < 7; k++) begin
      cfg(k[0], 8'h1A, pw_s[k], pw_b[k], 300);
      watch(512);
      chk("pwm high", n_hi[k[0]], pw_h[k]);
      chk("pwm events", n_ev[k[0]], 0);
      wr({1'b0, k[0], REG_CTL}, 8'h00);
    end
    // Clock source codes, stop codes included
    cfg(1'b0, 8'h10, 8'h00, 8'hFF, 40);
    for (int k = 0; k < 9; k++) begin
      cfg(1'b0, 8'(k << 4), 8'h00, 8'hFF, 40);
      watch(256);
      chk("source ticks", n_tick[0], src_n[k]);
    end
    // Emulator halt keeps only the fast oscillator running
    @(posedge i_core_clk);
    i_emu_halt <= 1'b1;
    for (int k = 1; k < 5; k *= 2) begin
      cfg(1'b0, 8'(k << 4), 8'h00, 8'hFF, 40);
      watch(256);
      chk("halt ticks", n_tick[0], (k == 2) ? 32 : 0);
    end
    @(posedge i_core_clk);
    i_emu_halt <= 1'b0;
    cfg(1'b0, 8'h10, 8'h00, 8'hFF, 10);
    i_clk_en <= 1'b0;
    watch(32);
    chk("frozen ticks", n_tick[0], 0);
    @(posedge i_core_clk);
    i_clk_en <= 1'b1;
    watch(32);
    chk("resumed ticks", n_tick[0], 32);
    report_and_stop();
  end

endmodule : tb

// ---- verilog/dtp_pkg.sv ----
package dtp_pkg;

  // ****************************************
  // Register map, word index per register
  // ****************************************
  localparam logic [3:0] ADR_CTL_A = 4'h0;
  localparam logic [3:0] ADR_SCALE_A = 4'h1;
  localparam logic [3:0] ADR_COUNT_A = 4'h2;
  localparam logic [3:0] ADR_BOUND_A = 4'h3;
  localparam logic [3:0] ADR_CTL_B = 4'h4;
  localparam logic [3:0] ADR_SCALE_B = 4'h5;
  localparam logic [3:0] ADR_COUNT_B = 4'h6;
  localparam logic [3:0] ADR_BOUND_B = 4'h7;
  localparam int unsigned ADR_TMR_BIT = 2;
  localparam int unsigned ADR_HOLE_BIT = 3;
  localparam logic [1:0] REG_CTL = 2'h0;
  localparam logic [1:0] REG_SCALE = 2'h1;
  localparam logic [1:0] REG_COUNT = 2'h2;
  localparam logic [1:0] REG_BOUND = 2'h3;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int unsigned CTL_CLK_HI = 7;
  localparam int unsigned CTL_CLK_LO = 4;
  localparam int unsigned CTL_OSEL_HI = 3;
  localparam int unsigned CTL_OSEL_LO = 2;
  localparam int unsigned CTL_PWM = 1;
  localparam int unsigned SCL_SIX = 7;
  localparam int unsigned SCL_PRE_HI = 6;
  localparam int unsigned SCL_PRE_LO = 5;
  localparam int unsigned SCL_DIV_HI = 4;
  localparam int unsigned SCL_DIV_LO = 0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] FULL_8 = 8'hFF;
  localparam logic [7:0] FULL_6 = 8'h3F;
  localparam logic [5:0] PRE_M1 = 6'h00;
  localparam logic [5:0] PRE_M4 = 6'h03;
  localparam logic [5:0] PRE_M16 = 6'h0F;
  localparam logic [5:0] PRE_M64 = 6'h3F;

  // Source pulse vector positions
  localparam int unsigned SRC_FAST = 0;
  localparam int unsigned SRC_SLOW = 1;
  localparam int unsigned SRC_A0 = 2;
  localparam int unsigned SRC_A3 = 3;
  localparam int unsigned SRC_A4 = 4;
  localparam int unsigned SRC_N = 5;

  typedef enum logic [3:0] {
    CLK_STOP = 4'h0,
    CLK_SYS = 4'h1,
    CLK_FAST = 4'h2,
    CLK_SLOW = 4'h4,
    CLK_PA0 = 4'h5,
    CLK_PA3 = 4'h6,
    CLK_PA4 = 4'h7
  } dtp_clk_e;

  typedef struct packed {
    logic [2:0] drv;
    logic [2:0] oe;
  } dtp_pins_s;

endpackage : dtp_pkg

// ---- verilog/dtp_top.sv ----
`timescale 1ns/1ps

// ****************************************
// One timer: source, prescale, scale, count
// ****************************************
module dtp_timer
  import dtp_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rstn, // Async reset
  input wire logic i_clk_en, // Freeze when low
  input wire logic i_emu_halt, // Emulator halt
  input wire logic [SRC_N-1:0] i_src_rise, // Synced source edges
  input wire logic i_wr, // Register write
  input wire logic [1:0] i_reg, // Register index
  input wire logic [7:0] i_wdata, // Write data
  output logic [7:0] o_ctl, // Control readback
  output logic [7:0] o_scale, // Scale readback
  output logic [7:0] o_count, // Counter value
  output logic [7:0] o_bound, // Bound readback
  output logic o_tick, // Timer tick pulse
  output logic o_event, // Period event pulse
  output dtp_pins_s o_pins // Output pins
);

  logic [7:0] ctl_r;
  logic [7:0] scl_r;
  logic [7:0] cnt_r;
  logic [7:0] bnd_r;
  logic [5:0] pre_r;
  logic [4:0] div_r;
  logic wave_r;
  logic event_r;

  wire logic [3:0] clk_sel = ctl_r[CTL_CLK_HI:CTL_CLK_LO];
  wire logic [1:0] osel = ctl_r[CTL_OSEL_HI:CTL_OSEL_LO];
  wire logic [1:0] pre_sel = scl_r[SCL_PRE_HI:SCL_PRE_LO];
  wire logic [4:0] div_val = scl_r[SCL_DIV_HI:SCL_DIV_LO];
  wire logic pwm = ctl_r[CTL_PWM];
  wire logic six = scl_r[SCL_SIX];

  // ****************************************
  // Clock source selection
  // ****************************************
  // Unlisted codes stop the timer; no crystal path exists
  wire logic fast_sel = (clk_sel == CLK_FAST);
  wire logic src_live = (clk_sel == CLK_SYS) |
    (fast_sel & i_src_rise[SRC_FAST]) |
    ((clk_sel == CLK_SLOW) & i_src_rise[SRC_SLOW]) |
    ((clk_sel == CLK_PA0) & i_src_rise[SRC_A0]) |
    ((clk_sel == CLK_PA3) & i_src_rise[SRC_A3]) |
    ((clk_sel == CLK_PA4) & i_src_rise[SRC_A4]);
  // Fast oscillator keeps feeding the timer through a halt
  wire logic src_go = src_live & (~i_emu_halt | fast_sel);

  // ****************************************
  // Prescaler and scaler
  // ****************************************
  wire logic [5:0] pre_mask = (pre_sel == 2'h0) ? PRE_M1 :
    (pre_sel == 2'h1) ? PRE_M4 :
    (pre_sel == 2'h2) ? PRE_M16 : PRE_M64;
  wire logic pre_hit = ((pre_r & pre_mask) == pre_mask);
  wire logic div_hit = (div_r >= div_val);
  wire logic tick = src_go & pre_hit & div_hit;
  wire logic [5:0] pre_nxt = src_go ? pre_r + 6'h01 : pre_r;
  wire logic [4:0] div_nxt = (src_go & pre_hit) ?
    (div_hit ? 5'h00 : div_r + 5'h01) : div_r;

  // ****************************************
  // Counter and waveform
  // ****************************************
  wire logic [7:0] full = six ? FULL_6 : FULL_8;
  wire logic per_wrap = tick & ~pwm & (cnt_r == bnd_r);
  wire logic pwm_wrap = tick & pwm & ((cnt_r & full) == full);
  wire logic cnt_wr = i_wr & (i_reg == REG_COUNT);
  // Software write wins over the tick that lands in the same cycle
  wire logic [7:0] cnt_nxt = cnt_wr ? i_wdata :
    (per_wrap | pwm_wrap) ? 8'h00 :
    tick ? cnt_r + 8'h01 : cnt_r;
  // Bound gives duty in PWM mode and period in period mode
  wire logic pwm_hi = ((cnt_nxt & full) <= bnd_r);
  wire logic wave_nxt = pwm ? pwm_hi : (per_wrap ^ wave_r);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_r <= REG_RST;
      scl_r <= REG_RST;
      bnd_r <= REG_RST;
    end else if (i_clk_en && i_wr) begin
      if (i_reg == REG_CTL) begin
        ctl_r <= i_wdata;
      end else if (i_reg == REG_SCALE) begin
        scl_r <= i_wdata;
      end else if (i_reg == REG_BOUND) begin
        bnd_r <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= REG_RST;
      pre_r <= 6'h00;
      div_r <= 5'h00;
      wave_r <= 1'b0;
      event_r <= 1'b0;
    end else if (i_clk_en) begin
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      div_r <= div_nxt;
      wave_r <= wave_nxt;
      event_r <= per_wrap;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire logic [2:0] pin_oe = (osel == 2'h1) ? 3'h1 :
    (osel == 2'h2) ? 3'h2 :
    (osel == 2'h3) ? 3'h4 : 3'h0;

  assign o_ctl = ctl_r;
  assign o_scale = scl_r;
  assign o_count = cnt_r;
  assign o_bound = bnd_r;
  assign o_tick = tick & i_clk_en;
  assign o_event = event_r;
  assign o_pins.oe = pin_oe;
  assign o_pins.drv = pin_oe & {3{wave_r}};

  // ****************************************
  // Checks
  // ****************************************
  property p_per_wrap;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && per_wrap && !cnt_wr) |=> (cnt_r == 8'h00);
  endproperty
  a_per_wrap: assert property (p_per_wrap) else $error("count did not wrap at bound");

  property p_toggle;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && per_wrap) |=> (wave_r != $past(wave_r)) && event_r;
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle or event at wrap");

  property p_event_only;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (event_r && $past(i_clk_en)) |-> $past(per_wrap) && !$past(pwm);
  endproperty
  a_event_only: assert property (p_event_only) else $error("event without wrap");

  property p_count_up;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && tick && !cnt_wr && !per_wrap && !pwm_wrap)
      |=> (cnt_r == $past(cnt_r) + 8'h01);
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not step up");

  property p_pwm8_wrap;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && tick && pwm && !six && cnt_r == 8'hFF && !cnt_wr) |=> (cnt_r == 8'h00);
  endproperty
  a_pwm8_wrap: assert property (p_pwm8_wrap) else $error("8-bit pwm wrap wrong");

  property p_pwm6_wrap;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && tick && pwm && six && cnt_r[5:0] == 6'h3F && !cnt_wr)
      |=> (cnt_r == 8'h00);
  endproperty
  a_pwm6_wrap: assert property (p_pwm6_wrap) else $error("6-bit pwm wrap wrong");

  property p_full_duty;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && pwm && ((six && bnd_r == 8'h3F) || bnd_r == 8'hFF)) |=> wave_r;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full bound not high");

  property p_halt;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_emu_halt && clk_sel != CLK_FAST) |-> !tick;
  endproperty
  a_halt: assert property (p_halt) else $error("tick during halt");

  property p_freeze;
    @(posedge i_core_clk) disable iff (!i_rstn)
    !i_clk_en |=> $stable(cnt_r) && $stable(div_r) && $stable(wave_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_sys_tick;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (clk_sel == CLK_SYS && !i_emu_halt && pre_sel == 2'h0 && div_val == 5'h00) |-> tick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("missing undivided tick");

  property p_route;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (osel == 2'h2) |-> (o_pins.oe == 3'h2) && (o_pins.drv[1] == wave_r);
  endproperty
  a_route: assert property (p_route) else $error("output routing wrong");

endmodule : dtp_timer

// Overview of operation
// - Two identical 8-bit PWM timers share one parameterless timer description.
// - Control bits 7:4 choose system clock, oscillators, or pins a0/a3/a4.
// - Fast oscillator source keeps the timer ticking while the emulator halts.
// - Control bits 3:2 route first timer to pin_b2, pin_a3 or pin_b4.
// - Second timer routes to pin_b5, pin_b6 or pin_b7.
// - Scale bits 6:5 prescale the source by 1, 4, 16 or 64.
// - Scale bits 4:0 divide further by value plus one, giving the tick.
// - The tick is offered out as a system clock source.
// - Counter counts up on ticks; software can write and read it.
// - Period mode counter returns to zero on reaching the bound.
// - Bound sets the period in period mode, duty in PWM mode.
// - Period mode gives a periodic waveform and a periodic event.
// - Period mode output is 50% duty at the documented frequency.
// - PWM with scale bit 7 clear: 256-tick period, high bound+1 ticks.
// - PWM with scale bit 7 set: 64-tick period, high bound+1 ticks, always high for bound 3F and above.
// - Bound at full scale holds the output permanently high.
// - Clock code 0001 system, output code 10 pin_a3, bit 1 clear period.
module dtp_top
  import dtp_pkg::*;
(
  input wire logic i_core_clk, // Core clock, 100 MHz
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_clk_en, // Freeze all state when low
  input wire logic i_emu_halt, // Emulator halt, core domain
  input wire logic i_fast_rc_osc, // Fast RC oscillator, async
  input wire logic i_slow_rc_osc, // Slow RC oscillator, async
  input wire logic i_pin_a0, // Pin a0 clock input, async
  input wire logic i_pin_a3, // Pin a3 clock input, async
  input wire logic i_pin_a4, // Pin a4 clock input, async
  input wire logic [3:0] i_addr, // Register index
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, cycle after strobe
  output logic o_timer_a_tick, // First timer tick pulse
  output logic o_timer_b_tick, // Second timer tick pulse
  output logic o_event_a, // First timer period event
  output logic o_event_b, // Second timer period event
  output dtp_pins_s o_pins_a, // pin_b2, pin_a3, pin_b4
  output dtp_pins_s o_pins_b // pin_b5, pin_b6, pin_b7
);

  // ****************************************
  // Source synchronisers and edge detect
  // ****************************************
  // Slow sources are sampled, so each must stay under half the core rate
  wire logic [SRC_N-1:0] src_raw = {i_pin_a4, i_pin_a3, i_pin_a0,
    i_slow_rc_osc, i_fast_rc_osc};
  logic [SRC_N-1:0] sync1_r;
  logic [SRC_N-1:0] sync2_r;
  logic [SRC_N-1:0] sync3_r;
  wire logic [SRC_N-1:0] src_rise = sync2_r & ~sync3_r;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else if (i_clk_en) begin
      sync1_r <= src_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ****************************************
  // Register bus decode
  // ****************************************
  wire logic hole = i_addr[ADR_HOLE_BIT];
  wire logic sel_b = i_addr[ADR_TMR_BIT];
  wire logic wr_a = i_wr & ~hole & ~sel_b;
  wire logic wr_b = i_wr & ~hole & sel_b;
  wire logic [1:0] reg_idx = i_addr[1:0];

  logic [7:0] ctl_a, scl_a, cnt_a, bnd_a;
  logic [7:0] ctl_b, scl_b, cnt_b, bnd_b;
  logic [7:0] rdata_r;

  function automatic logic [7:0] reg_pick(input logic [1:0] idx,
      input logic [7:0] c, input logic [7:0] s,
      input logic [7:0] n, input logic [7:0] b);
    reg_pick = (idx == REG_CTL) ? c :
      (idx == REG_SCALE) ? s :
      (idx == REG_COUNT) ? n : b;
  endfunction : reg_pick

  wire logic [7:0] rd_val = hole ? 8'h00 :
    sel_b ? reg_pick(reg_idx, ctl_b, scl_b, cnt_b, bnd_b) :
    reg_pick(reg_idx, ctl_a, scl_a, cnt_a, bnd_a);

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= 8'h00;
    end else if (i_clk_en) begin
      rdata_r <= i_rd ? rd_val : 8'h00;
    end
  end

  assign o_rdata = rdata_r;

  // ****************************************
  // Timer instances
  // ****************************************
  dtp_timer u_timer_a (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .i_emu_halt(i_emu_halt),
    .i_src_rise(src_rise),
    .i_wr(wr_a),
    .i_reg(reg_idx),
    .i_wdata(i_wdata),
    .o_ctl(ctl_a),
    .o_scale(scl_a),
    .o_count(cnt_a),
    .o_bound(bnd_a),
    .o_tick(o_timer_a_tick),
    .o_event(o_event_a),
    .o_pins(o_pins_a)
  );

  dtp_timer u_timer_b (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .i_emu_halt(i_emu_halt),
    .i_src_rise(src_rise),
    .i_wr(wr_b),
    .i_reg(reg_idx),
    .i_wdata(i_wdata),
    .o_ctl(ctl_b),
    .o_scale(scl_b),
    .o_count(cnt_b),
    .o_bound(bnd_b),
    .o_tick(o_timer_b_tick),
    .o_event(o_event_b),
    .o_pins(o_pins_b)
  );

  // ****************************************
  // Checks
  // ****************************************
  property p_read_late;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && i_rd && !i_wr && i_addr == ADR_BOUND_A) |=> (o_rdata == $past(bnd_a));
  endproperty
  a_read_late: assert property (p_read_late) else $error("read data wrong");

  property p_hole;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_clk_en && hole) |=> (o_rdata == 8'h00);
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");

endmodule : dtp_top
